/* verilog/sfp_pkg.sv */
// shared constants and types for the serial flash front end and its bus master
package sfp_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ADDR_W        = 17;
   localparam int unsigned PAGE_W        = 8;
   localparam int unsigned BLK_SEL_W     = 2;

   localparam int unsigned PROG_TIME_US  = 2000;
   localparam int unsigned ERASE_TIME_US = 40000;
   localparam int unsigned SRW_TIME_US   = 10;
   localparam int unsigned PROG_CYC      = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned ERASE_CYC     = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned SRW_CYC       = SRW_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned SCK_HALF      = 8;

   localparam logic [7:0] WRITE_ARM_CMD    = 8'h06;
   localparam logic [7:0] WRITE_DISARM_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] DATA_READ_CMD    = 8'h03;
   localparam logic [7:0] PAGE_WRITE_CMD   = 8'h02;
   localparam logic [7:0] BLOCK_WIPE_CMD   = 8'hd8;
   localparam logic [7:0] CHIP_WIPE_CMD    = 8'hc7;

   localparam int unsigned SR_BUSY  = 0;
   localparam int unsigned SR_ARM   = 1;
   localparam int unsigned SR_GLO   = 2;
   localparam int unsigned SR_GHI   = 3;
   localparam int unsigned SR_LOCK  = 7;
   localparam logic [1:0]  GUARD_RST = 2'h0;
   localparam logic        LOCK_RST  = 1'h0;
   localparam logic [7:0]  ERASED    = 8'hff;

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_DATA = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam int unsigned CTRL_SEL   = 0;
   localparam int unsigned CTRL_CPOL  = 1;
   localparam int unsigned CTRL_PAUSE = 2;
   localparam int unsigned CTRL_WPLOW = 3;
   localparam logic [3:0]  CTRL_RST   = 4'h0;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_WALK = 2'b01,
      ENG_WAIT = 2'b10
   } sfp_eng_e;

   typedef enum logic [1:0] {
      K_SR    = 2'b00,
      K_PROG  = 2'b01,
      K_ERASE = 2'b10
   } sfp_kind_e;
endpackage : sfp_pkg

/* verilog/sfp_link_if.sv */
// four-wire serial link plus pause and write-protect pins
`timescale 1ns/100ps
interface sfp_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic wp_n;
   logic hold_n;
   logic miso_q;
   logic miso_oe;
   logic miso;

   // released output floats high through a pull-up
   assign miso = miso_oe ? miso_q : 1'b1;

   modport dev (input sclk, cs_n, mosi, wp_n, hold_n, output miso_q, miso_oe);
   modport host (output sclk, cs_n, mosi, wp_n, hold_n, input miso);
endinterface : sfp_link_if

/* verilog/sfp_flash_end.sv */
// serial flash device end: link front end, status, protection and array
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// What this block does
// - data input captured on serial clock rise
// - output bits shifted out on clock fall
// - deselected means output released, standby
// - ignore instructions until first select fall
// - pause releases output, freezes transfer position
// - master pauses only while device selected
// - both clock idle levels shift data identically; pause only engages with clock low
// - 256-byte pages, 512 in all
// - four 32 KiB blocks from address zero
// - program clears bits; erase only sets them
// - busy reads 1, only status reads served
// - busy returns to 0 at cycle end
// - disarmed latch rejects all modifying commands
// - guard bits changed only by status write
// - guard pair decodes protected upper blocks
// - guard writes refused in hardware guard mode
// - chip wipe only with guard pair zero
// - lock plus protect low freezes status
// - latch cleared at reset and command completion
// - pause starts and ends with clock low
// - deselect while paused resets the interface
// - modifying commands need whole bytes clocked
module sfp_flash_end #(
   parameter int unsigned ADDR_W    = sfp_pkg::ADDR_W,    // array address width
   parameter int unsigned PROG_CYC  = sfp_pkg::PROG_CYC,  // page write busy cycles
   parameter int unsigned ERASE_CYC = sfp_pkg::ERASE_CYC  // wipe busy cycles
) (
   input  wire logic       ref_clk_i,  // system clock
   input  wire logic       rst_n_i,    // async reset, active low
   sfp_link_if.dev         link,       // serial link pins
   output logic      [7:0] status_o    // status byte mirror
);
   logic [4:0]          meta_q;
   logic [4:0]          pin_q;
   logic                sclk_prev_q;
   logic                cs_prev_q;
   logic                paused_q;
   logic                hold_blk_q;
   logic                seen_fall_q;
   logic [2:0]          bit_cnt_q;
   logic [2:0]          nbytes_q;
   logic [7:0]          shreg_q;
   logic [7:0]          cmd_q;
   logic [7:0]          sr_new_q;
   logic [23:0]         addr_q;
   logic [7:0]          pg_ofs_q;
   logic [7:0]          out_q;
   logic                out_act_q;
   logic                drive_q;
   logic                miso_q;
   logic                oe_q;
   logic [7:0]          buf_q [256];
   logic [255:0]        bvld_q;
   logic [7:0]          mem_q [2**ADDR_W];
   logic                arm_q;
   logic [1:0]          guard_q;
   logic                lock_q;
   logic [7:0]          sr_hold_q;
   sfp_pkg::sfp_eng_e   eng_q;
   sfp_pkg::sfp_kind_e  kind_q;
   logic [ADDR_W-1:0]   cur_q;
   logic [ADDR_W-1:0]   last_q;
   logic [31:0]         timer_q;
   logic [7:0]          status_q;

   // synchronised pins: {hold_n, wp_n, mosi, cs_n, sclk}
   wire sclk_s = pin_q[0];
   wire cs_s   = pin_q[1];
   wire mosi_s = pin_q[2];
   wire wp_s   = pin_q[3];
   wire hold_s = pin_q[4];

   // a clock rise landing with the select fall is a polarity switch, not a data bit
   wire rise    = sclk_s & ~sclk_prev_q & ~paused_q & ~cs_s & ~cs_prev_q
                  & seen_fall_q;
   wire fall    = ~sclk_s & sclk_prev_q & ~paused_q & ~cs_s;
   wire cs_rise = cs_s & ~cs_prev_q;
   wire busy    = (eng_q != sfp_pkg::ENG_IDLE);
   wire [7:0] byte_in = {shreg_q[6:0], mosi_s};
   wire byte_done = rise & (bit_cnt_q == 3'd7);
   wire [ADDR_W-1:0] rd_addr = (nbytes_q == 3'd3) ?
                               ADDR_W'({addr_q[15:0], byte_in}) : addr_q[ADDR_W-1:0];
   wire page_data = byte_done & ~busy & (cmd_q == sfp_pkg::PAGE_WRITE_CMD) & (nbytes_q >= 3'd4);
   wire [1:0] blk  = addr_q[ADDR_W-1 -: 2];
   wire hw_guard   = lock_q & ~wp_s;
   wire blk_guarded = (guard_q == 2'b11) | (guard_q[1] & blk[1]) |
                      ((guard_q == 2'b01) & (blk == 2'b11));
   wire ok      = cs_rise & seen_fall_q & ~busy;
   wire mod_ok  = ok & arm_q & (bit_cnt_q == 3'd0);
   wire go_sr   = mod_ok & (cmd_q == sfp_pkg::STATUS_WRITE_CMD) & (nbytes_q >= 3'd2)
                  & ~hw_guard;
   wire go_pg   = mod_ok & (cmd_q == sfp_pkg::PAGE_WRITE_CMD) & (nbytes_q >= 3'd5)
                  & ~blk_guarded;
   wire go_blk  = mod_ok & (cmd_q == sfp_pkg::BLOCK_WIPE_CMD) & (nbytes_q >= 3'd4)
                  & ~blk_guarded;
   wire go_chip = mod_ok & (cmd_q == sfp_pkg::CHIP_WIPE_CMD) & (nbytes_q >= 3'd1)
                  & (guard_q == 2'b00);
   wire eng_done = (eng_q == sfp_pkg::ENG_WAIT) & (timer_q == 32'h0);

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         // idle pin levels, so no false clock edge or guard follows reset
         meta_q      <= 5'h1a;
         pin_q       <= 5'h1a;
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end
      else
      begin
         meta_q      <= {link.hold_n, link.wp_n, link.mosi, link.cs_n, link.sclk};
         pin_q       <= meta_q;
         sclk_prev_q <= sclk_s;
         cs_prev_q   <= cs_s;
      end
   end

   // first select fall after reset opens the device to instructions
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         seen_fall_q <= 1'b0;
      else if (~cs_s & cs_prev_q)
         seen_fall_q <= 1'b1;
   end

   // pause tracking; a mid-pause deselect blocks re-entry until pause pin rises
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         paused_q   <= 1'b0;
         hold_blk_q <= 1'b0;
      end
      else
      begin
         if (cs_s)
            paused_q <= 1'b0;
         else if (!paused_q && !hold_s && !sclk_s && !hold_blk_q)
            paused_q <= 1'b1;
         else if (paused_q && hold_s && !sclk_s)
            paused_q <= 1'b0;
         if (hold_s)
            hold_blk_q <= 1'b0;
         else if (cs_s && paused_q)
            hold_blk_q <= 1'b1;
      end
   end

   // serial shifter, byte counter and read-back loading
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bit_cnt_q <= 3'h0;
         nbytes_q  <= 3'h0;
         shreg_q   <= 8'h0;
         cmd_q     <= 8'h0;
         sr_new_q  <= 8'h0;
         addr_q    <= 24'h0;
         pg_ofs_q  <= 8'h0;
         out_q     <= 8'h0;
         out_act_q <= 1'b0;
      end
      else if (cs_s)
      begin
         bit_cnt_q <= 3'h0;
         nbytes_q  <= 3'h0;
         out_act_q <= 1'b0;
      end
      else if (rise)
      begin
         shreg_q   <= byte_in;
         bit_cnt_q <= bit_cnt_q + 3'd1;
         if (bit_cnt_q == 3'd7)
         begin
            if (nbytes_q != 3'd7)
               nbytes_q <= nbytes_q + 3'd1;
            if (nbytes_q == 3'd0)
               cmd_q <= byte_in;
            if (nbytes_q == 3'd1)
               sr_new_q <= byte_in;
            if (nbytes_q >= 3'd1 && nbytes_q <= 3'd3)
               addr_q <= {addr_q[15:0], byte_in};
            if (nbytes_q == 3'd3)
               pg_ofs_q <= byte_in;
            if (page_data)
               pg_ofs_q <= pg_ofs_q + 8'd1;
            if (nbytes_q == 3'd0 && byte_in == sfp_pkg::STATUS_READ_CMD)
            begin
               out_q     <= status_q;
               out_act_q <= 1'b1;
            end
            else if (nbytes_q != 3'd0 && cmd_q == sfp_pkg::STATUS_READ_CMD)
               out_q <= status_q;
            else if (nbytes_q >= 3'd3 && cmd_q == sfp_pkg::DATA_READ_CMD && !busy)
            begin
               out_q     <= mem_q[rd_addr];
               out_act_q <= 1'b1;
               addr_q    <= {{(24 - ADDR_W){1'b0}}, rd_addr + ADDR_W'(1)};
            end
         end
      end
      else if (fall && out_act_q)
         out_q <= {out_q[6:0], 1'b0};
   end

   // output pin: driven only while selected, not paused and in a read phase
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         miso_q  <= 1'b0;
         drive_q <= 1'b0;
         oe_q    <= 1'b0;
      end
      else
      begin
         if (cs_s)
            drive_q <= 1'b0;
         else if (fall && out_act_q)
         begin
            miso_q  <= out_q[7];
            drive_q <= 1'b1;
         end
         oe_q <= ~cs_s & ~paused_q & drive_q;
      end
   end

   // page buffer; stays frozen while busy so a stray command cannot disturb a program
   always_ff @(posedge ref_clk_i)
   begin
      if (page_data)
         buf_q[pg_ofs_q] <= bvld_q[pg_ofs_q] ? (buf_q[pg_ofs_q] & byte_in) : byte_in;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bvld_q <= '0;
      else if (byte_done && nbytes_q == 3'd0 && !busy)
         bvld_q <= '0;
      else if (page_data)
         bvld_q[pg_ofs_q] <= 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         arm_q <= 1'b0;
      else if (eng_done)
         arm_q <= 1'b0;
      else if (ok && cmd_q == sfp_pkg::WRITE_DISARM_CMD && nbytes_q != 3'd0)
         arm_q <= 1'b0;
      else if (ok && cmd_q == sfp_pkg::WRITE_ARM_CMD && nbytes_q != 3'd0)
         arm_q <= 1'b1;
   end

   // busy engine: walk the target range of a program or wipe (status writes skip the walk), then hold busy for the cycle time
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         eng_q     <= sfp_pkg::ENG_IDLE;
         kind_q    <= sfp_pkg::K_SR;
         cur_q     <= '0;
         last_q    <= '0;
         timer_q   <= 32'h0;
         sr_hold_q <= 8'h0;
      end
      else
      begin
         case (eng_q)
            sfp_pkg::ENG_IDLE:
            begin
               if (go_sr)
               begin
                  kind_q    <= sfp_pkg::K_SR;
                  sr_hold_q <= sr_new_q;
                  timer_q   <= 32'(sfp_pkg::SRW_CYC - 1);
                  eng_q     <= sfp_pkg::ENG_WAIT;
               end
               else if (go_pg)
               begin
                  kind_q  <= sfp_pkg::K_PROG;
                  cur_q   <= {addr_q[ADDR_W-1:8], 8'h00};
                  last_q  <= {addr_q[ADDR_W-1:8], 8'hff};
                  timer_q <= 32'(PROG_CYC - 1);
                  eng_q   <= sfp_pkg::ENG_WALK;
               end
               else if (go_blk || go_chip)
               begin
                  kind_q  <= sfp_pkg::K_ERASE;
                  cur_q   <= go_chip ? '0 : {blk, {(ADDR_W - 2){1'b0}}};
                  last_q  <= go_chip ? '1 : {blk, {(ADDR_W - 2){1'b1}}};
                  timer_q <= 32'(ERASE_CYC - 1);
                  eng_q   <= sfp_pkg::ENG_WALK;
               end
            end
            sfp_pkg::ENG_WALK:
            begin
               cur_q <= cur_q + ADDR_W'(1);
               if (cur_q == last_q)
                  eng_q <= sfp_pkg::ENG_WAIT;
            end
            sfp_pkg::ENG_WAIT:
            begin
               if (timer_q == 32'h0)
                  eng_q <= sfp_pkg::ENG_IDLE;
               else
                  timer_q <= timer_q - 32'd1;
            end
            default:
               eng_q <= sfp_pkg::ENG_IDLE;
         endcase
      end
   end

   // array has no reset: its content is meant to survive
   always_ff @(posedge ref_clk_i)
   begin
      if (eng_q == sfp_pkg::ENG_WALK)
         mem_q[cur_q] <= (kind_q == sfp_pkg::K_PROG) ?
                         (mem_q[cur_q] & (bvld_q[cur_q[7:0]] ? buf_q[cur_q[7:0]] : 8'hff)) :
                         sfp_pkg::ERASED;
   end

   // non-volatile bits; reset stands in for power-up at delivery state
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         guard_q <= sfp_pkg::GUARD_RST;
         lock_q  <= sfp_pkg::LOCK_RST;
      end
      else if (eng_done && kind_q == sfp_pkg::K_SR)
      begin
         guard_q <= sr_hold_q[sfp_pkg::SR_GHI:sfp_pkg::SR_GLO];
         lock_q  <= sr_hold_q[sfp_pkg::SR_LOCK];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         status_q <= 8'h0;
      else
         status_q <= {lock_q, 3'b000, guard_q, arm_q, busy};
   end

   assign link.miso_q  = miso_q;
   assign link.miso_oe = oe_q;
   assign status_o     = status_q;
endmodule : sfp_flash_end

/* verilog/sfp_spi_host.sv */
// bus master end: register-driven byte shifter for the serial flash link
`timescale 1ns/100ps
module sfp_spi_host #(
   parameter int unsigned HALF = sfp_pkg::SCK_HALF  // clock cycles per serial half period
) (
   input  wire logic       ref_clk_i,  // system clock
   input  wire logic       rst_n_i,    // async reset, active low
   input  wire logic [3:0] addr_i,     // register byte address
   input  wire logic [7:0] wdata_i,    // write data
   input  wire logic       wr_i,       // write strobe
   input  wire logic       rd_i,       // read strobe
   output logic      [7:0] rdata_o,    // read data, cycle after strobe
   sfp_link_if.host        link        // serial link pins
);
   logic [3:0]  ctrl_q;
   logic [7:0]  tx_q;
   logic [7:0]  rx_q;
   logic [7:0]  rdata_q;
   logic        busy_q;
   logic [3:0]  ph_q;
   logic [7:0]  hcnt_q;
   logic [1:0]  miso_sync_q;
   logic        sclk_q;
   logic        mosi_q;
   logic        cs_n_q;
   logic        hold_n_q;
   logic        wp_n_q;

   wire start = wr_i & (addr_i == sfp_pkg::REG_DATA) & ~busy_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ctrl_q <= sfp_pkg::CTRL_RST;
      else if (wr_i && addr_i == sfp_pkg::REG_CTRL)
         ctrl_q <= wdata_i[3:0];
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         miso_sync_q <= 2'b11;
      else
         miso_sync_q <= {miso_sync_q[0], link.miso};
   end

   // a byte is 16 half periods; even ones low with new data, odd ones high
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy_q <= 1'b0;
         ph_q   <= 4'h0;
         hcnt_q <= 8'h0;
         tx_q   <= 8'h0;
         rx_q   <= 8'h0;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
      end
      else if (!busy_q)
      begin
         sclk_q <= ctrl_q[sfp_pkg::CTRL_CPOL];
         if (start)
         begin
            busy_q <= 1'b1;
            ph_q   <= 4'h0;
            hcnt_q <= 8'h0;
            tx_q   <= wdata_i;
         end
      end
      else
      begin
         if (hcnt_q == 8'h0)
         begin
            if (!ph_q[0])
            begin
               sclk_q <= 1'b0;
               mosi_q <= tx_q[7];
               tx_q   <= {tx_q[6:0], 1'b0};
            end
            else
            begin
               sclk_q <= 1'b1;
               rx_q   <= {rx_q[6:0], miso_sync_q[1]};
            end
         end
         if (hcnt_q == 8'(HALF - 1))
         begin
            hcnt_q <= 8'h0;
            ph_q   <= ph_q + 4'd1;
            if (ph_q == 4'hf)
               busy_q <= 1'b0;
         end
         else
            hcnt_q <= hcnt_q + 8'd1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cs_n_q   <= 1'b1;
         hold_n_q <= 1'b1;
         wp_n_q   <= 1'b1;
      end
      else
      begin
         cs_n_q   <= ~ctrl_q[sfp_pkg::CTRL_SEL];
         hold_n_q <= ~(ctrl_q[sfp_pkg::CTRL_PAUSE] & ctrl_q[sfp_pkg::CTRL_SEL]);
         wp_n_q   <= ~ctrl_q[sfp_pkg::CTRL_WPLOW];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_q <= 8'h0;
      else if (rd_i)
      begin
         case (addr_i)
            sfp_pkg::REG_CTRL: rdata_q <= {4'h0, ctrl_q};
            sfp_pkg::REG_DATA: rdata_q <= rx_q;
            sfp_pkg::REG_STAT: rdata_q <= {7'h0, busy_q};
            default:           rdata_q <= 8'h0;
         endcase
      end
      else
         rdata_q <= 8'h0;
   end

   assign link.sclk   = sclk_q;
   assign link.mosi   = mosi_q;
   assign link.cs_n   = cs_n_q;
   assign link.hold_n = hold_n_q;
   assign link.wp_n   = wp_n_q;
   assign rdata_o     = rdata_q;
endmodule : sfp_spi_host

/* test/sfp_link_monitor.sv */
// link checker for the serial flash front end
`timescale 1ns/100ps
module sfp_link_monitor (
   input wire logic ref_clk_i,  // system clock
   input wire logic rst_n_i,    // async reset, active low
   input wire logic sclk,       // serial clock
   input wire logic cs_n,       // select, active low
   input wire logic mosi,       // host data
   input wire logic wp_n,       // write protect, active low
   input wire logic hold_n,     // pause, active low
   input wire logic miso_q,     // device data bit
   input wire logic miso_oe,    // device drive enable
   input wire logic miso        // resolved wire
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // six cycles covers the device's two-flop pin sync plus its output register
   chk_desel_release: assert property (cs_n [*6] |-> !miso_oe)
      else $error("output driven while deselected");
   chk_pause_release: assert property ((!cs_n && !hold_n && !sclk) [*6] |-> !miso_oe)
      else $error("output driven while paused");
   chk_out_on_fall: assert property (miso_oe && $changed(miso_q) |-> !sclk)
      else $error("output bit changed while clock high");
   chk_oe_start_low: assert property ($rose(miso_oe) |-> !sclk)
      else $error("output enabled outside a low clock phase");
   chk_oe_sel_only: assert property ($rose(miso_oe) |-> !cs_n && hold_n)
      else $error("output enabled while deselected or paused");
   chk_hold_sel: assert property (!hold_n |-> !cs_n)
      else $error("pause asserted without select");
   chk_mosi_setup: assert property (!cs_n && $rose(sclk) |-> $stable(mosi) ##1 $stable(mosi) [*3])
      else $error("data in moved around a clock rise");
   chk_idle_clk: assert property (cs_n && $past(cs_n) |-> $stable(sclk))
      else $error("clock toggled while deselected");
   chk_wire_float: assert property (!miso_oe |-> miso)
      else $error("released output not pulled high");
   cov_guard_low: cover property (!wp_n && !cs_n);
endmodule : sfp_link_monitor

/* test/serial_flash_protect_front_end_tb_top.sv */
// self-checking bench joining the bus master end to the flash end
`timescale 1ns/100ps
module serial_flash_protect_front_end_tb_top;
   logic       ref_clk_i   = 1'b0;
   logic       rst_n_i     = 1'b0;
   logic [3:0] addr        = 4'h0;
   logic [7:0] wdata       = 8'h00;
   logic       wr          = 1'b0;
   logic       rd          = 1'b0;
   logic       cpol        = 1'b0;
   logic       wpl         = 1'b0;
   logic [7:0] rdata;
   logic [7:0] status;
   logic [7:0] b;
   logic [7:0] s;
   int         mismatches  = 0;
   int         checks_done = 0;
   int         cycles      = 0;

   sfp_link_if link ();
   sfp_spi_host u_sfp_spi_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
   // small address width keeps wipe walks short: blocks are addr[9:8]
   sfp_flash_end #(.ADDR_W(10), .PROG_CYC(20), .ERASE_CYC(20)) u_sfp_flash_end (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link), .status_o(status));
   sfp_link_monitor u_sfp_link_monitor (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .wp_n(link.wp_n),
      .hold_n(link.hold_n), .miso_q(link.miso_q), .miso_oe(link.miso_oe), .miso(link.miso));

   initial
   begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         mismatches++;
         summarize;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk_i);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk_i);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic ctrl(input logic pause, input logic sel);
      wr_reg(sfp_pkg::REG_CTRL, {4'h0, wpl, pause, cpol, sel});
   endtask : ctrl

   // a new byte is only offered once the shifter reports idle
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      logic [7:0] st;
      wr_reg(sfp_pkg::REG_DATA, tx);
      st = 8'h01;
      for (int i = 0; i < 100 && st[0] !== 1'b0; i++)
         rd_reg(sfp_pkg::REG_STAT, st);
      if (st[0] !== 1'b0)
      begin
         mismatches++;
         $display("[ERR] %0t shifter stuck busy", $time);
      end
      rd_reg(sfp_pkg::REG_DATA, rx);
   endtask : xfer

   task automatic frame(input logic [7:0] q[$]);
      ctrl(1'b0, 1'b1);
      foreach (q[i])
         xfer(q[i], b);
      ctrl(1'b0, 1'b0);
      repeat (8) @(posedge ref_clk_i);
   endtask : frame

   task automatic rdsr(output logic [7:0] st);
      frame('{sfp_pkg::STATUS_READ_CMD, 8'h00});
      st = b;
   endtask : rdsr

   task automatic arm;
      frame('{sfp_pkg::WRITE_ARM_CMD});
   endtask : arm

   task automatic wait_ready(output logic [7:0] st);
      st = 8'h01;
      for (int i = 0; i < 20 && st[0] !== 1'b0; i++)
         rdsr(st);
      if (st[0] !== 1'b0)
      begin
         mismatches++;
         $display("[ERR] %0t busy never cleared", $time);
      end
   endtask : wait_ready

   task automatic t_reset;
      chk(status, 8'h00);
      chk({7'h0, link.miso_oe}, 8'h00);
   endtask : t_reset

   task automatic t_status_write;
      frame('{sfp_pkg::STATUS_WRITE_CMD, 8'h0c});
      rdsr(s);
      chk(s, 8'h00);
      arm;
      rdsr(s);
      chk(s, 8'h02);
      frame('{sfp_pkg::STATUS_WRITE_CMD, 8'h84});
      rdsr(s);
      chk({7'h0, s[0]}, 8'h01);
      wait_ready(s);
      chk(s, 8'h84);
      chk(status, 8'h84);
   endtask : t_status_write

   task automatic t_hw_guard;
      wpl = 1'b1;
      arm;
      frame('{sfp_pkg::STATUS_WRITE_CMD, 8'h00});
      rdsr(s);
      chk(s, 8'h86);
      wpl = 1'b0;
      frame('{sfp_pkg::STATUS_WRITE_CMD, 8'h08});
      wait_ready(s);
      chk(s, 8'h08);
   endtask : t_hw_guard

   task automatic t_guards;
      arm;
      frame('{sfp_pkg::CHIP_WIPE_CMD});
      rdsr(s);
      chk(s, 8'h0a);
      frame('{sfp_pkg::PAGE_WRITE_CMD, 8'h00, 8'h02, 8'h00, 8'h00});
      rdsr(s);
      chk(s, 8'h0a);
      frame('{sfp_pkg::STATUS_WRITE_CMD, 8'h00});
      wait_ready(s);
      arm;
      frame('{sfp_pkg::CHIP_WIPE_CMD});
      rdsr(s);
      chk({7'h0, s[0]}, 8'h01);
      wait_ready(s);
      chk(s, 8'h00);
   endtask : t_guards

   task automatic t_page_pause;
      arm;
      frame('{sfp_pkg::PAGE_WRITE_CMD, 8'h00, 8'h01, 8'h00, 8'h5a, 8'hf0});
      wait_ready(s);
      arm;
      frame('{sfp_pkg::PAGE_WRITE_CMD, 8'h00, 8'h01, 8'h00, 8'h0f});
      wait_ready(s);
      ctrl(1'b0, 1'b1);
      xfer(sfp_pkg::DATA_READ_CMD, b);
      xfer(8'h00, b);
      xfer(8'h01, b);
      xfer(8'h00, b);
      xfer(8'h00, b);
      chk(b, 8'h0a);
      ctrl(1'b1, 1'b1);
      repeat (20) @(posedge ref_clk_i);
      chk({7'h0, link.miso_oe}, 8'h00);
      ctrl(1'b0, 1'b1);
      repeat (10) @(posedge ref_clk_i);
      xfer(8'h00, b);
      chk(b, 8'hf0);
      ctrl(1'b0, 1'b0);
      repeat (8) @(posedge ref_clk_i);
   endtask : t_page_pause

   task automatic t_mode3;
      cpol = 1'b1;
      arm;
      rdsr(s);
      chk(s, 8'h02);
      frame('{sfp_pkg::WRITE_DISARM_CMD});
      rdsr(s);
      chk(s, 8'h00);
   endtask : t_mode3

   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      t_reset;
      t_status_write;
      t_hw_guard;
      t_guards;
      t_page_pause;
      t_mode3;
      summarize;
   end
endmodule : serial_flash_protect_front_end_tb_top
